// file: ilr_top.sv
// Interrupt line request configuration block with AXI4-Lite slave
//
// Overview of operation
// - Every source line has its own independent configuration register.
// - Bit 31 shows whether the line has a request pending and ignores writes.
// - Writing one to bit 30 sets and to bit 29 clears the soft request; both read zero.
// - Bit 28 gates writes to the priority field.
// - Polarity, enable, target and priority change only when their gate bit is set in the same write.
// - Bit 26 gates writes to the enable field.
// - Bit 25 gates writes to the polarity field.
// - Bit 27 gates writes to the target field; zero leaves target unchanged.
// - All gate bits read back as zero.
// - Reserved bits read zero and software writes zeros to them.
// - Bit 17 set means the source is active low; reset gives active high.
// - Bit 16 enables the request; when zero the request is discarded.
// - Bit 8 routes the request to the fast input when one, normal input when zero.
// - The four-bit priority in bits 3..0 masks the request when zero.
// - Priority one is lowest and fifteen highest among competing requests.
`timescale 1ns/1ps
module ilr_top (
  input  wire logic                                  mclk,
  input  wire logic                                  rst,
  input  wire logic [ilr_pkg::NUM_LINES-1:0]         src_lines,
  input  wire logic [ilr_pkg::ADDR_W-1:0]            s_axi_awaddr,
  input  wire logic                                  s_axi_awvalid,
  output logic                                       s_axi_awready,
  input  wire logic [31:0]                           s_axi_wdata,
  input  wire logic [3:0]                            s_axi_wstrb,
  input  wire logic                                  s_axi_wvalid,
  output logic                                       s_axi_wready,
  output logic [1:0]                                 s_axi_bresp,
  output logic                                       s_axi_bvalid,
  input  wire logic                                  s_axi_bready,
  input  wire logic [ilr_pkg::ADDR_W-1:0]            s_axi_araddr,
  input  wire logic                                  s_axi_arvalid,
  output logic                                       s_axi_arready,
  output logic [31:0]                                s_axi_rdata,
  output logic [1:0]                                 s_axi_rresp,
  output logic                                       s_axi_rvalid,
  input  wire logic                                  s_axi_rready,
  output logic                                       irq_q,
  output logic                                       fast_req_q,
  output logic                                       normal_req_q,
  output logic [ilr_pkg::PRIO_W-1:0]                 fast_prio_q,
  output logic [ilr_pkg::PRIO_W-1:0]                 normal_prio_q,
  output logic [ilr_pkg::LINE_IDX_W-1:0]             fast_line_q,
  output logic [ilr_pkg::LINE_IDX_W-1:0]             normal_line_q
);

  localparam int N = ilr_pkg::NUM_LINES;

  // Word decode; is_line and line_of shared by both channels, is_evt by the write channel only
  function automatic logic is_line(input logic [ilr_pkg::ADDR_W-1:0] a);
    return a[ilr_pkg::ADDR_W-1:7] == ilr_pkg::LINE_BASE_ADDR[ilr_pkg::ADDR_W-1:7];
  endfunction : is_line

  function automatic logic [ilr_pkg::LINE_IDX_W-1:0] line_of(input logic [ilr_pkg::ADDR_W-1:0] a);
    return a[2 +: ilr_pkg::LINE_IDX_W];
  endfunction : line_of

  function automatic logic is_evt(input logic [ilr_pkg::ADDR_W-1:0] a);
    return a == ilr_pkg::EVT_STATUS_ADDR || a == ilr_pkg::EVT_ENABLE_ADDR || a == ilr_pkg::EVT_CLEAR_ADDR;
  endfunction : is_evt

  logic [N-1:0] src_sync;

  ilr_sync #(
    .W (N)
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  (src_lines),
    .dout (src_sync)
  );

  // Write channel: address and data taken in either order
  logic                       aw_held_q;
  logic                       w_held_q;
  logic [ilr_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0]                wdata_q;
  logic [3:0]                 wstrb_q;
  logic                       do_write;
  logic                       aw_take;
  logic                       w_take;
  logic                       ar_take;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end else if (aw_take) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (w_take) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !aw_take && !s_axi_bvalid;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_q && !w_take && !s_axi_bvalid;
    end
  end

  // Only full-word writes act, so gate bits and fields land together
  logic wr_full;
  logic wr_line;
  logic wr_known;
  logic wr_evt_clear;
  logic wr_evt_enable;

  assign wr_full = wstrb_q == 4'hf;
  assign wr_line = is_line(awaddr_q);
  assign wr_known = wr_line || is_evt(awaddr_q);
  assign wr_evt_clear = do_write && wr_full && awaddr_q == ilr_pkg::EVT_CLEAR_ADDR;
  assign wr_evt_enable = do_write && wr_full && awaddr_q == ilr_pkg::EVT_ENABLE_ADDR;

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Refused writes still answer, so a stray address cannot hang the master
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_bresp <= ilr_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bresp <= wr_known ? ilr_pkg::RESP_OKAY : ilr_pkg::RESP_SLVERR;
    end
  end

  // Per-line registers
  logic [31:0]       line_rdata [N];
  ilr_pkg::ilr_req_t line_req   [N];
  logic [N-1:0]      pend_rise;

  for (genvar i = 0; i < N; i++) begin : g_line
    ilr_pkg::ilr_wr_t lw;
    assign lw.wr = do_write && wr_full && wr_line &&
                   line_of(awaddr_q) == ilr_pkg::LINE_IDX_W'(i);
    assign lw.wdata = wdata_q;
    ilr_line u_line (
      .mclk      (mclk),
      .rst       (rst),
      .src_level (src_sync[i]),
      .wr        (lw),
      .rdata     (line_rdata[i]),
      .req       (line_req[i]),
      .pend_rise (pend_rise[i])
    );
  end

  // Sticky pending-edge events; a new event beats a same-cycle clear
  logic [N-1:0] evt_q;
  logic [N-1:0] evt_en_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      evt_q <= ilr_pkg::RST_EVT;
    end else if (wr_evt_clear) begin
      evt_q <= (evt_q & ~wdata_q) | pend_rise;
    end else begin
      evt_q <= evt_q | pend_rise;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      evt_en_q <= ilr_pkg::RST_EVT;
    end else if (wr_evt_enable) begin
      evt_en_q <= wdata_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(evt_q & evt_en_q);
    end
  end

  // Read channel
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
    end
  end

  // Read word picked ahead of the take so the answer is one flop deep
  logic [31:0] rd_word;
  logic        rd_err;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err = 1'b0;
    if (is_line(s_axi_araddr)) begin
      rd_word = line_rdata[line_of(s_axi_araddr)];
    end else begin
      case (s_axi_araddr)
        ilr_pkg::EVT_STATUS_ADDR: begin
          rd_word = evt_q;
        end
        ilr_pkg::EVT_ENABLE_ADDR: begin
          rd_word = evt_en_q;
        end
        ilr_pkg::EVT_CLEAR_ADDR: begin
          rd_word = 32'h0000_0000;
        end
        default: begin
          rd_err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= ilr_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_err ? ilr_pkg::RESP_SLVERR : ilr_pkg::RESP_OKAY;
    end
  end

  // Highest priority per target; lowest line index wins a tie
  logic                           f_v;
  logic                           n_v;
  logic [ilr_pkg::PRIO_W-1:0]     f_p;
  logic [ilr_pkg::PRIO_W-1:0]     n_p;
  logic [ilr_pkg::LINE_IDX_W-1:0] f_l;
  logic [ilr_pkg::LINE_IDX_W-1:0] n_l;

  // Strictly higher only, so the earlier line keeps a tie
  function automatic logic beats(input logic                       have,
                                 input logic [ilr_pkg::PRIO_W-1:0] p,
                                 input logic [ilr_pkg::PRIO_W-1:0] best);
    return !have || p > best;
  endfunction : beats

  always_comb begin
    f_v = 1'b0;
    f_p = '0;
    f_l = '0;
    for (int i = 0; i < N; i++) begin
      if (line_req[i].valid && line_req[i].target_fast) begin
        if (beats(f_v, line_req[i].priority_level, f_p)) begin
          f_v = 1'b1;
          f_p = line_req[i].priority_level;
          f_l = ilr_pkg::LINE_IDX_W'(i);
        end
      end
    end
  end

  always_comb begin
    n_v = 1'b0;
    n_p = '0;
    n_l = '0;
    for (int i = 0; i < N; i++) begin
      if (line_req[i].valid && !line_req[i].target_fast) begin
        if (beats(n_v, line_req[i].priority_level, n_p)) begin
          n_v = 1'b1;
          n_p = line_req[i].priority_level;
          n_l = ilr_pkg::LINE_IDX_W'(i);
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fast_req_q <= 1'b0;
      fast_prio_q <= '0;
      fast_line_q <= '0;
    end else begin
      fast_req_q <= f_v;
      fast_prio_q <= f_p;
      fast_line_q <= f_l;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      normal_req_q <= 1'b0;
      normal_prio_q <= '0;
      normal_line_q <= '0;
    end else begin
      normal_req_q <= n_v;
      normal_prio_q <= n_p;
      normal_line_q <= n_l;
    end
  end

endmodule : ilr_top

// file: ilr_pkg.sv
// Package for the interrupt line request configuration block
package ilr_pkg;

  localparam int NUM_LINES = 32;
  localparam int LINE_IDX_W = 5;
  localparam int ADDR_W = 12;

  // Register map: one word per line, then status block
  localparam logic [ADDR_W-1:0] LINE_BASE_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] EVT_STATUS_ADDR = 12'h100;
  localparam logic [ADDR_W-1:0] EVT_ENABLE_ADDR = 12'h104;
  localparam logic [ADDR_W-1:0] EVT_CLEAR_ADDR = 12'h108;

  // Field positions
  localparam int PENDING_BIT = 31;
  localparam int SOFT_SET_BIT = 30;
  localparam int SOFT_CLR_BIT = 29;
  localparam int WE_PRIO_BIT = 28;
  localparam int WE_TARGET_BIT = 27;
  localparam int WE_ENABLE_BIT = 26;
  localparam int WE_POL_BIT = 25;
  localparam int POL_BIT = 17;
  localparam int ENABLE_BIT = 16;
  localparam int TARGET_BIT = 8;
  localparam int PRIO_LSB = 0;
  localparam int PRIO_W = 4;

  // Reset values
  localparam logic RST_POL = 1'b0;
  localparam logic RST_ENABLE = 1'b0;
  localparam logic RST_TARGET = 1'b0;
  localparam logic [PRIO_W-1:0] RST_PRIO = 4'h0;
  localparam logic [NUM_LINES-1:0] RST_EVT = 32'h0000_0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic polarity_low;
    logic enable;
    logic target_fast;
    logic [PRIO_W-1:0] priority_level;
  } ilr_cfg_t;

  typedef struct packed {
    logic valid;
    logic target_fast;
    logic [PRIO_W-1:0] priority_level;
  } ilr_req_t;

  typedef struct packed {
    logic wr;
    logic [31:0] wdata;
  } ilr_wr_t;

endpackage : ilr_pkg

// file: ilr_line.sv
// One interrupt line: config register, soft request, qualified request
`timescale 1ns/1ps
module ilr_line (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              src_level,
  input  wire ilr_pkg::ilr_wr_t  wr,
  output logic [31:0]            rdata,
  output ilr_pkg::ilr_req_t      req,
  output logic                   pend_rise
);

  ilr_pkg::ilr_cfg_t cfg_q;
  logic              soft_q;
  logic              pend_q;
  logic              pending;

  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_q.polarity_low <= ilr_pkg::RST_POL;
      cfg_q.enable <= ilr_pkg::RST_ENABLE;
      cfg_q.target_fast <= ilr_pkg::RST_TARGET;
      cfg_q.priority_level <= ilr_pkg::RST_PRIO;
    end else if (wr.wr) begin
      if (wr.wdata[ilr_pkg::WE_POL_BIT]) begin
        cfg_q.polarity_low <= wr.wdata[ilr_pkg::POL_BIT];
      end
      if (wr.wdata[ilr_pkg::WE_ENABLE_BIT]) begin
        cfg_q.enable <= wr.wdata[ilr_pkg::ENABLE_BIT];
      end
      if (wr.wdata[ilr_pkg::WE_TARGET_BIT]) begin
        cfg_q.target_fast <= wr.wdata[ilr_pkg::TARGET_BIT];
      end
      if (wr.wdata[ilr_pkg::WE_PRIO_BIT]) begin
        cfg_q.priority_level <= wr.wdata[ilr_pkg::PRIO_LSB +: ilr_pkg::PRIO_W];
      end
    end
  end

  // Clear wins if both set and clear are written together
  always_ff @(posedge mclk) begin
    if (rst) begin
      soft_q <= 1'b0;
    end else if (wr.wr && wr.wdata[ilr_pkg::SOFT_CLR_BIT]) begin
      soft_q <= 1'b0;
    end else if (wr.wr && wr.wdata[ilr_pkg::SOFT_SET_BIT]) begin
      soft_q <= 1'b1;
    end
  end

  assign pending = (src_level ^ cfg_q.polarity_low) | soft_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= pending;
    end
  end

  assign pend_rise = pending & ~pend_q;

  // Gates, write gates and reserved bits read zero
  always_comb begin
    rdata = 32'h0000_0000;
    rdata[ilr_pkg::PENDING_BIT] = pending;
    rdata[ilr_pkg::POL_BIT] = cfg_q.polarity_low;
    rdata[ilr_pkg::ENABLE_BIT] = cfg_q.enable;
    rdata[ilr_pkg::TARGET_BIT] = cfg_q.target_fast;
    rdata[ilr_pkg::PRIO_LSB +: ilr_pkg::PRIO_W] = cfg_q.priority_level;
  end

  always_comb begin
    req.valid = pending && cfg_q.enable && (cfg_q.priority_level != '0);
    req.target_fast = cfg_q.target_fast;
    req.priority_level = cfg_q.priority_level;
  end

endmodule : ilr_line

// file: ilr_sync.sv
// Three-stage synchroniser with second/third agreement
`timescale 1ns/1ps
module ilr_sync #(
  parameter int W = 32
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic [W-1:0]      dout
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      dout <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Change accepted only when the last two stages agree
      dout <= (s2_q & s3_q) | (dout & (s2_q | s3_q));
    end
  end

endmodule : ilr_sync

// file: ilr_monitor.sv
// Port checker for the interrupt line request configuration block
`timescale 1ns/1ps
module ilr_monitor (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq_q,
  input wire logic        fast_req_q,
  input wire logic [3:0]  fast_prio_q,
  input wire logic        normal_req_q,
  input wire logic [3:0]  normal_prio_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [11:0] aw_q;
  logic [11:0] ar_q;
  // Addresses kept so responses can be judged against what was asked
  always_ff @(posedge mclk) begin
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
  end
  always_ff @(posedge mclk) begin
    if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
  end
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data missing");
  rd_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read data repeated");
  bus_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write accepted early");
  rd_zero_bits_a: assert property (s_axi_rvalid && ar_q[11:7] == 5'h00 |->
    (s_axi_rdata & 32'h7ffc_fef0) == 32'h0) else $error("gate or reserved bit read nonzero");
  line_okay_a: assert property (s_axi_bvalid && aw_q[11:7] == 5'h00
    |-> s_axi_bresp == ilr_pkg::RESP_OKAY) else $error("line write refused");
  unmapped_err_a: assert property (s_axi_bvalid && aw_q >= 12'h10c |-> s_axi_bresp == ilr_pkg::RESP_SLVERR)
    else $error("unmapped write accepted");
  fast_prio_a: assert property (fast_req_q == (fast_prio_q != 4'h0))
    else $error("fast request and priority disagree");
  normal_prio_a: assert property (normal_req_q == (normal_prio_q != 4'h0))
    else $error("normal request and priority disagree");
  rst_quiet_a: assert property (disable iff (1'b0) rst |=> !irq_q && !fast_req_q && !normal_req_q)
    else $error("output active after reset");
  cover property (fast_req_q && fast_prio_q == 4'hf);
  cover property (normal_req_q && !fast_req_q);
  cover property (irq_q);
  cover property (s_axi_bvalid && s_axi_bresp == ilr_pkg::RESP_SLVERR);
endmodule : ilr_monitor

// file: ilr_top_tb.sv
// Self-checking bench for the interrupt line request configuration block
`timescale 1ns/1ps
module ilr_top_tb;
  typedef struct {logic [31:0] w; logic [31:0] e;} ilr_row_t;
  logic        mclk = 1'b0, rst = 1'b1, irq_q, fast_req_q, normal_req_q;
  logic [31:0] src_lines = 32'h0, s_axi_wdata = 32'h0, s_axi_rdata;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [3:0]  s_axi_wstrb = 4'h0, fast_prio_q, normal_prio_q;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [4:0]  fast_line_q, normal_line_q;
  int          mismatches = 0;
  int          compares = 0;
  // Row sequence on one line: each row builds on the state left by the last
  ilr_row_t    rows [6] = '{'{32'h0003_0105, 32'h0000_0000}, '{32'h1e03_0105, 32'h8003_0105},
                            '{32'h1000_0009, 32'h8003_0109}, '{32'h0200_0000, 32'h0001_0109},
                            '{32'h0400_0000, 32'h0000_0109}, '{32'h0800_0000, 32'h0000_0009}};
  always #2.5 mclk = ~mclk;
  ilr_top dut (.mclk, .rst, .src_lines, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
               .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
               .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
               .s_axi_rready, .irq_q, .fast_req_q, .normal_req_q, .fast_prio_q, .normal_prio_q,
               .fast_line_q, .normal_line_q);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Ready lines stay high throughout, so a response is taken the edge it shows
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0,
                    input logic [3:0] s = 4'hf);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge mclk);
      if (!ad && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, er);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
  endtask : rd
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #20000;
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(12'h000, 32'h0);
    rd(ilr_pkg::EVT_ENABLE_ADDR, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(12'h00c, rows[i].w);
      repeat (4) @(posedge mclk);
      rd(12'h00c, rows[i].e);
    end
    rd(12'h010, 32'h0);
    wr(12'h010, 32'h1000_0003, ilr_pkg::RESP_OKAY, 4'h1);
    rd(12'h010, 32'h0);
    wr(12'h014, 32'h1401_0007);
    wr(12'h014, 32'h4000_0000);
    repeat (3) @(posedge mclk);
    chk({normal_req_q, normal_prio_q, normal_line_q, fast_req_q}, {1'b1, 4'h7, 5'h05, 1'b0});
    wr(12'h014, 32'h8000_0000);
    rd(12'h014, 32'h8001_0007);
    wr(12'h014, 32'h6000_0000);
    repeat (3) @(posedge mclk);
    rd(12'h014, 32'h0001_0007);
    chk(normal_req_q, 1'b0);
    src_lines <= 32'h0000_00c0;
    wr(12'h018, 32'h1800_010c);
    repeat (6) @(posedge mclk);
    chk(fast_req_q, 1'b0);
    wr(12'h018, 32'h0401_0000);
    wr(12'h01c, 32'h1c01_010f);
    repeat (3) @(posedge mclk);
    chk({fast_req_q, fast_prio_q, fast_line_q}, {1'b1, 4'hf, 5'h07});
    wr(12'h01c, 32'h1000_0000);
    repeat (3) @(posedge mclk);
    chk({fast_req_q, fast_prio_q, fast_line_q}, {1'b1, 4'hc, 5'h06});
    rd(ilr_pkg::EVT_STATUS_ADDR, 32'h0000_00e8);
    wr(ilr_pkg::EVT_ENABLE_ADDR, 32'h0000_0020);
    repeat (2) @(posedge mclk);
    chk(irq_q, 1'b1);
    wr(ilr_pkg::EVT_ENABLE_ADDR, 32'h0);
    repeat (2) @(posedge mclk);
    chk(irq_q, 1'b0);
    wr(ilr_pkg::EVT_CLEAR_ADDR, 32'hffff_ffff);
    rd(ilr_pkg::EVT_STATUS_ADDR, 32'h0);
    wr(12'h200, 32'h0000_0001, ilr_pkg::RESP_SLVERR);
    rd(12'h200, 32'h0, ilr_pkg::RESP_SLVERR);
    // Reset again in mid-run with a source still high
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk({irq_q, fast_req_q}, 2'b00);
    repeat (6) @(posedge mclk);
    rd(12'h018, 32'h8000_0000);
    give_verdict();
  end
endmodule : ilr_top_tb
bind ilr_top ilr_monitor mon (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .irq_q, .fast_req_q, .fast_prio_q, .normal_req_q, .normal_prio_q);
